// file: verilog/acp_defs.svh
// constants of the converter serial port: field positions, reset values, timing
// assumes the includer has a 250 MHz system clock
`ifndef ACP_DEFS_SVH
`define ACP_DEFS_SVH

// frame layout in serial clock periods
`define ACP_FRAME_EDGES 5'h10
`define ACP_CFG_BITS 4'h8
`define ACP_LEAD_ZEROS 5'h04
`define ACP_RES_BITS 12
// acquisition_interval and conversion_interval in half serial periods
`define ACP_ACQ_HALF_PERIODS 3
`define ACP_CONV_HALF_PERIODS 29
// falling edge that ends acquisition
`define ACP_HOLD_EDGE 5'h02

// configuration word fields
`define ACP_CFG_RESET 8'h00
`define ACP_CFG_REF_BIT 5
`define ACP_CFG_DUAL_BIT 4
`define ACP_CFG_CH_BIT 3
`define ACP_CFG_PM_HI 1
`define ACP_CFG_PM_LO 0
`define ACP_PM_SHDN_CS 2'h0
`define ACP_PM_NORMAL 2'h1
`define ACP_PM_SHDN_AFTER 2'h2
`define ACP_PM_STANDBY 2'h3

// timing
`define ACP_SYS_PERIOD_PS 4000
`define ACP_T_DOUT_ON_NS 60
`define ACP_T_DOUT_OFF_NS 80
`define ACP_T_POWERUP_NS 5000
`define ACP_DOUT_ON_CYC ((`ACP_T_DOUT_ON_NS * 1000) / `ACP_SYS_PERIOD_PS)
`define ACP_DOUT_OFF_CYC ((`ACP_T_DOUT_OFF_NS * 1000) / `ACP_SYS_PERIOD_PS)
`define ACP_POWERUP_CYC ((`ACP_T_POWERUP_NS * 1000 + `ACP_SYS_PERIOD_PS - 1) / `ACP_SYS_PERIOD_PS)

`endif

// file: verilog/acp_pkg.sv
// types of the converter serial port
// constants stand in acp_defs.svh
package acp_pkg;
   typedef enum logic [1:0] {
      ACP_PWR_OFF,
      ACP_PWR_WAKING,
      ACP_PWR_ON
   } acp_pwr_e;

   typedef logic [7:0] acp_cfg_t;
   typedef logic [11:0] acp_res_t;
endpackage

// file: verilog/acp_cfg_if.sv
// carrier of the configuration word from the serial clock side to the system side
// word is stable whenever the toggle has settled
`timescale 1ns/1ps
interface acp_cfg_if;
   import acp_pkg::*;
   acp_cfg_t cfg_word;
   logic cfg_tgl;

   modport src (output cfg_word, output cfg_tgl);
   modport dst (input cfg_word, input cfg_tgl);
endinterface

// file: verilog/acp_serial_link.sv
// serial clock side of the converter port: config capture, result shift, hold timing
// runs only on host serial clock edges; frame select clears the frame logic
`timescale 1ns/1ps
`include "acp_defs.svh"
module acp_serial_link
   import acp_pkg::*;
(
   // link pins
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic din_in,
   input wire logic rst_n_in,
   // converter core, serial clock domain
   input wire acp_res_t core_bits_in,
   output logic dout_out,
   output logic hold_out,
   // towards system side
   acp_cfg_if.src cfg_port
);
   logic [4:0] rise_cnt_q;
   logic [4:0] fall_cnt_q;
   logic [6:0] cfg_shift_q;
   acp_cfg_t cfg_word_q;
   logic cfg_tgl_q;
   logic [10:0] sh_q;
   logic dout_q;
   logic hold_q;

   wire rise_live = rise_cnt_q != `ACP_FRAME_EDGES;
   wire fall_live = fall_cnt_q != `ACP_FRAME_EDGES;
   wire cfg_edge = rise_cnt_q < 5'(`ACP_CFG_BITS);
   wire cfg_last = rise_cnt_q == 5'(`ACP_CFG_BITS - 4'h1);
   wire [4:0] fall_next = fall_cnt_q + 5'h01;
   wire res_first = fall_next == (`ACP_LEAD_ZEROS + 5'h01);
   wire res_later = fall_next > (`ACP_LEAD_ZEROS + 5'h01);

   always_ff @(posedge sclk_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         rise_cnt_q <= 5'h00;
         cfg_shift_q <= 7'h00;
      end else if (rise_live) begin
         rise_cnt_q <= rise_cnt_q + 5'h01;
         if (cfg_edge) begin
            cfg_shift_q <= {cfg_shift_q[5:0], din_in};
         end
      end
   end

   always_ff @(posedge sclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_word_q <= `ACP_CFG_RESET;
         cfg_tgl_q <= 1'b0;
      end else if (!cs_n_in && rise_live && cfg_last) begin
         cfg_word_q <= {cfg_shift_q, din_in};
         cfg_tgl_q <= ~cfg_tgl_q;
      end
   end

   always_ff @(negedge sclk_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         fall_cnt_q <= 5'h00;
         dout_q <= 1'b0;
         sh_q <= 11'h000;
         hold_q <= 1'b0;
      end else if (fall_live) begin
         fall_cnt_q <= fall_next;
         if (fall_next == `ACP_HOLD_EDGE) begin
            hold_q <= 1'b1;
         end
         if (res_first) begin
            dout_q <= core_bits_in[11];
            sh_q <= core_bits_in[10:0];
         end else if (res_later) begin
            dout_q <= sh_q[10];
            sh_q <= {sh_q[9:0], 1'b0};
         end else begin
            dout_q <= 1'b0;
         end
      end
   end

   assign dout_out = dout_q;
   assign hold_out = hold_q;
   assign cfg_port.cfg_word = cfg_word_q;
   assign cfg_port.cfg_tgl = cfg_tgl_q;
endmodule

// file: verilog/acp_conv_port.sv
// top of the converter serial port: system side power control and output enable
// assumes the host keeps the serial clock still outside frames
`timescale 1ns/1ps
`include "acp_defs.svh"
module acp_conv_port
   import acp_pkg::*;
#(
   parameter int unsigned POWERUP_CYC = `ACP_POWERUP_CYC
)
(
   // system clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // serial link
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic din_in,
   output logic dout_out,
   output logic dout_oe_out,
   // converter core
   input wire acp_res_t core_bits_in,
   output logic hold_out,
   output logic pd_out,
   output logic standby_out,
   output logic ready_out,
   // configuration in force
   output logic ref_off_out,
   output logic dual_out,
   output logic chan_out,
   output logic [1:0] pm_mode_out
);
   acp_cfg_if cfg_bus ();

   acp_serial_link u_link (
      .sclk_in(sclk_in),
      .cs_n_in(cs_n_in),
      .din_in(din_in),
      .rst_n_in(rst_n_in),
      .core_bits_in(core_bits_in),
      .dout_out(dout_out),
      .hold_out(hold_out),
      .cfg_port(cfg_bus.src)
   );

   // frame select and config toggle synchronisers
   logic cs_meta_q;
   logic cs_sync_q;
   logic tgl_meta_q;
   logic tgl_sync_q;
   logic tgl_prev_q;
   acp_cfg_t cfg_q;
   logic oe_q;
   logic pd_q;
   logic stby_q;
   logic ready_q;
   acp_pwr_e pwr_q;
   acp_pwr_e pwr_d;
   logic [15:0] wake_cnt_q;
   logic [15:0] wake_cnt_d;

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         cs_meta_q <= 1'b1;
         cs_sync_q <= 1'b1;
         tgl_meta_q <= 1'b0;
         tgl_sync_q <= 1'b0;
         tgl_prev_q <= 1'b0;
      end else begin
         cs_meta_q <= cs_n_in;
         cs_sync_q <= cs_meta_q;
         tgl_meta_q <= cfg_bus.cfg_tgl;
         tgl_sync_q <= tgl_meta_q;
         tgl_prev_q <= tgl_sync_q;
      end
   end

   // new word is stable long before the toggle settles here
   wire cfg_load = tgl_sync_q ^ tgl_prev_q;
   wire [1:0] pm_mode = cfg_q[`ACP_CFG_PM_HI:`ACP_CFG_PM_LO];
   wire idle = cs_sync_q;
   wire shdn_mode = (pm_mode == `ACP_PM_SHDN_CS) || (pm_mode == `ACP_PM_SHDN_AFTER);
   wire stby_mode = pm_mode == `ACP_PM_STANDBY;
   wire pd_d = shdn_mode && idle;
   wire stby_d = stby_mode && idle;
   wire wake_done = wake_cnt_q == 16'(POWERUP_CYC - 1);

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         cfg_q <= `ACP_CFG_RESET;
      end else if (cfg_load) begin
         cfg_q <= cfg_bus.cfg_word;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= ~cs_sync_q;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         pd_q <= 1'b1;
         stby_q <= 1'b0;
      end else begin
         pd_q <= pd_d;
         stby_q <= stby_d;
      end
   end

   // wake timer: converter settles after leaving shutdown
   always_comb begin
      pwr_d = pwr_q;
      wake_cnt_d = wake_cnt_q;
      case (pwr_q)
         ACP_PWR_OFF: begin
            wake_cnt_d = 16'h0000;
            if (!pd_q) begin
               pwr_d = ACP_PWR_WAKING;
            end
         end
         ACP_PWR_WAKING: begin
            wake_cnt_d = wake_cnt_q + 16'h0001;
            if (pd_q) begin
               pwr_d = ACP_PWR_OFF;
            end else if (wake_done) begin
               pwr_d = ACP_PWR_ON;
            end
         end
         ACP_PWR_ON: begin
            if (pd_q) begin
               pwr_d = ACP_PWR_OFF;
            end
         end
         default: begin
            pwr_d = ACP_PWR_OFF;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         pwr_q <= ACP_PWR_OFF;
         wake_cnt_q <= 16'h0000;
         ready_q <= 1'b0;
      end else begin
         pwr_q <= pwr_d;
         wake_cnt_q <= wake_cnt_d;
         // ready drops in the same cycle as power-down rises
         ready_q <= (pwr_d == ACP_PWR_ON) && !pd_d;
      end
   end

   assign dout_oe_out = oe_q;
   assign pd_out = pd_q;
   assign standby_out = stby_q;
   assign ready_out = ready_q;
   assign ref_off_out = cfg_q[`ACP_CFG_REF_BIT];
   assign dual_out = cfg_q[`ACP_CFG_DUAL_BIT];
   assign chan_out = cfg_q[`ACP_CFG_CH_BIT];
   assign pm_mode_out = pm_mode;
endmodule

// file: dv/acp_host_model.sv
// host side of the link: frame select, serial clock, config bits
// sclk idles high and runs only inside frames
`timescale 1ns/1ps
module acp_host_model (
   // link pins
   output logic sclk_out,
   output logic cs_n_out,
   output logic din_out,
   input wire logic dout_in
);
   initial begin
      sclk_out = 1'b1;
      cs_n_out = 1'b1;
      din_out = 1'b0;
   end
   task automatic frame(input logic [7:0] cfg, input int n, output logic [15:0] rd);
      rd = 16'h0000;
      #1.3 cs_n_out = 1'b0;
      #40;
      for (int i = 0; i < n; i++) begin
         // bit set at fall, held past rise
         sclk_out = 1'b0;
         din_out = (i < 8) ? cfg[7 - i] : 1'b0;
         #80 sclk_out = 1'b1;
         if (i < 16) rd[15 - i] = dout_in;
         #80;
      end
      cs_n_out = 1'b1;
      din_out = ~din_out;
   endtask
endmodule

// file: dv/acp_conv_port_checker.sv
// assertions on the converter port pins
// bound to every acp_conv_port instance
`timescale 1ns/1ps
module acp_conv_port_checker #(parameter int unsigned POWERUP_CYC = 8) (
   // clock, reset, link
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic cs_n_in,
   // watched outputs
   input wire logic dout_oe_out,
   input wire logic hold_out,
   input wire logic pd_out,
   input wire logic ready_out,
   input wire logic [1:0] pm_mode_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   oe_on_a: assert property ($fell(cs_n_in) |-> ##[1:15] dout_oe_out)
      else $error("output not driven after select fell");
   oe_off_a: assert property ($rose(cs_n_in) |-> ##[1:20] !dout_oe_out)
      else $error("output not released after select rose");
   pd_idle_a: assert property ((pm_mode_out == 2'h0 && cs_n_in) [*6] |-> pd_out)
      else $error("converter awake while idle");
   pd_wake_a: assert property ((pm_mode_out == 2'h0 && !cs_n_in) [*6] |-> !pd_out)
      else $error("converter asleep in frame");
   hold_idle_a: assert property (cs_n_in |-> !hold_out)
      else $error("hold outside frame");
   hold_sel_a: assert property ($rose(hold_out) |-> !cs_n_in)
      else $error("hold without select");
   ready_wait_a: assert property ($fell(pd_out) |-> !ready_out [*8] ##[2:3] ready_out)
      else $error("ready timing wrong");
   pd_ready_a: assert property (pd_out |-> !ready_out)
      else $error("ready while shut down");
   cover property ($fell(cs_n_in));
   cover property ($rose(hold_out));
   cover property ($rose(ready_out));
endmodule
bind acp_conv_port acp_conv_port_checker #(.POWERUP_CYC(POWERUP_CYC)) i_acp_conv_port_checker (
   .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in), .dout_oe_out(dout_oe_out),
   .hold_out(hold_out), .pd_out(pd_out), .ready_out(ready_out), .pm_mode_out(pm_mode_out));

// file: dv/testbench.sv
// self-checking bench of acp_conv_port with a host model on the link
// 250 MHz system clock; host makes a 160 ns serial clock
`timescale 1ns/1ps
module testbench;
   import acp_pkg::*;
   logic clk_sys_in, rst_n_in, sclk, cs_n, din, dout, dout_oe, hold, pd, standby, ready, ref_off, dual, chan;
   logic [1:0] pm_mode;
   acp_res_t core_bits;
   logic [15:0] rd;
   int n_fail, comparisons;
   acp_conv_port #(.POWERUP_CYC(8)) i_acp_conv_port (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .sclk_in(sclk), .cs_n_in(cs_n), .din_in(din), .dout_out(dout), .dout_oe_out(dout_oe),
      .core_bits_in(core_bits), .hold_out(hold), .pd_out(pd), .standby_out(standby), .ready_out(ready),
      .ref_off_out(ref_off), .dual_out(dual), .chan_out(chan), .pm_mode_out(pm_mode));
   acp_host_model i_acp_host_model (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din),
      .dout_in(dout_oe ? dout : ~dout));
   int sclk_falls, hold_at;
   // falling serial edges of the current frame, taken when hold rises
   always @(negedge sclk or posedge cs_n) begin
      if (cs_n) sclk_falls = 0;
      else sclk_falls++;
   end
   always @(posedge hold) hold_at = sclk_falls;
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // bounded wait for release, then settle
   task automatic settle();
      int i;
      for (i = 0; i < 20 && dout_oe !== 1'b0; i++) @(posedge clk_sys_in);
      if (i == 20) begin
         n_fail++;
         $display("[ERR] dout_oe release expected 0 seen %b", dout_oe);
         final_report();
      end
      repeat (8) @(negedge clk_sys_in);
   endtask
   task automatic cfg_chk(input logic [15:0] exp);
      chk("cfg", exp, {11'h000, ref_off, dual, chan, pm_mode});
   endtask
   task automatic t_reset();
      repeat (12) @(negedge clk_sys_in);
      rst_n_in = 1'b1;
      @(negedge clk_sys_in);
      chk("pd", 16'h0001, pd);
      cfg_chk(16'h0000);
      $display("t_reset done");
   endtask
   task automatic t_convert();
      core_bits = 12'hA5C;
      hold_at = 0;
      i_acp_host_model.frame(8'h31, 20, rd);
      chk("frame", 16'h0A5C, rd);
      chk("ready", 16'h0001, ready);
      chk("hold edge", 16'h0002, 16'(hold_at));
      settle();
      cfg_chk(16'h0019);
      chk("pd ready", 16'h0001, {pd, ready});
      $display("t_convert done");
   endtask
   task automatic t_short();
      i_acp_host_model.frame(8'hFF, 4, rd);
      chk("short", 16'h0000, rd);
      settle();
      cfg_chk(16'h0019);
      $display("t_short done");
   endtask
   task automatic t_power();
      core_bits = 12'h3C1;
      i_acp_host_model.frame(8'h0B, 16, rd);
      settle();
      cfg_chk(16'h0007);
      chk("standby", 16'h0001, {pd, standby});
      i_acp_host_model.frame(8'h00, 16, rd);
      chk("frame", 16'h03C1, rd);
      settle();
      chk("shutdown", 16'h0002, {pd, ready});
      core_bits = 12'h812;
      i_acp_host_model.frame(8'h02, 16, rd);
      chk("frame", 16'h0812, rd);
      chk("ready", 16'h0001, ready);
      settle();
      cfg_chk(16'h0002);
      chk("pm2 shutdown", 16'h0002, {pd, ready});
      $display("t_power done");
   endtask
   initial begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      rst_n_in = 1'b0;
      core_bits = 12'h000;
      n_fail = 0;
      comparisons = 0;
      t_reset();
      t_convert();
      t_short();
      t_power();
      rst_n_in = 1'b0;
      t_reset();
      final_report();
   end
   initial begin
      #100000;
      n_fail++;
      $display("[ERR] run time expected done seen timeout");
      final_report();
   end
endmodule
